/* File: reload_holder.sv */
`timescale 1ns/1ps
`include "timer_control_map.svh"
module reload_holder (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic buffer_en,
   input wire logic write_en,
   input wire logic [`RELOAD_WIDTH-1:0] write_value,
   input wire logic update_event,
   output logic [`RELOAD_WIDTH-1:0] buffer_value,
   output logic [`RELOAD_WIDTH-1:0] active_value
);
   logic [`RELOAD_WIDTH-1:0] buffer_q;
   logic [`RELOAD_WIDTH-1:0] active_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buffer_q <= `RELOAD_RESET;
      end else if (write_en) begin
         buffer_q <= write_value;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_q <= `RELOAD_RESET;
      end else if (write_en && !buffer_en) begin
         active_q <= write_value;
      end else if (update_event) begin
         active_q <= buffer_q;
      end
   end

   assign buffer_value = buffer_q;
   assign active_value = active_q;
endmodule : reload_holder

/* File: sampling_divider.sv */
`timescale 1ns/1ps
`include "timer_control_map.svh"
module sampling_divider
   import timer_control_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] div_code,
   output logic sample_tick
);
   logic [`DIV_COUNT_WIDTH-1:0] count_q;
   logic [`DIV_COUNT_WIDTH-1:0] last_count;

   always_comb begin
      case (sampling_div_t'(div_code))
         DIV_TWO: last_count = `DIV_TWO_LAST;
         DIV_FOUR: last_count = `DIV_FOUR_LAST;
         // Reserved code falls back to one kernel period
         default: last_count = 2'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= 2'h0;
      end else if (count_q >= last_count) begin
         count_q <= 2'h0;
      end else begin
         count_q <= count_q + 2'h1;
      end
   end

   assign sample_tick = (count_q >= last_count);
endmodule : sampling_divider

/* File: timer_control_map.svh */
`ifndef TIMER_CONTROL_MAP_SVH
`define TIMER_CONTROL_MAP_SVH
`define CTRL_ONE_OFFSET 8'h00
`define RELOAD_ACTIVE_OFFSET 8'h04
`define RELOAD_BUFFER_OFFSET 8'h08
`define IRQ_STATUS_OFFSET 8'h0C
`define IRQ_MASK_OFFSET 8'h10
`define EVENT_CTRL_OFFSET 8'h14
`define CTRL_ONE_RESET 32'h0000_0000
`define CTRL_ONE_WMASK 32'h0000_038F
`define RUN_BIT 0
`define SUPPRESS_BIT 1
`define SOURCE_BIT 2
`define SINGLE_SHOT_BIT 3
`define BUFFER_EN_BIT 7
`define DIV_LSB 8
`define DIV_MSB 9
`define UG_BIT 0
`define IRQ_UPDATE_BIT 0
`define IRQ_HALT_BIT 1
`define IRQ_WIDTH 2
`define RELOAD_WIDTH 16
`define RELOAD_RESET 16'hFFFF
`define DIV_COUNT_WIDTH 2
`define DIV_TWO_LAST 2'h1
`define DIV_FOUR_LAST 2'h3
`endif

/* File: timer_control_one.sv */
`timescale 1ns/1ps
`include "timer_control_map.svh"
module timer_control_one
   import timer_control_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic counter_wrap,
   input wire logic slave_update,
   input wire logic slave_reset,
   input wire logic trigger_start,
   output logic counter_run,
   output logic update_event,
   output logic update_request,
   output logic counter_reinit,
   output logic sample_tick,
   output logic [15:0] reload_active,
   output logic irq
);
   logic [31:0] ctrl_q;
   logic [`IRQ_WIDTH-1:0] status_q;
   logic [`IRQ_WIDTH-1:0] mask_q;
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic update_event_q;
   logic update_request_q;
   logic reinit_q;
   logic tick_q;
   logic irq_q;
   logic tick_raw;
   logic do_write;
   logic [31:0] wmask;
   logic ug_write;
   logic reload_write;
   logic any_update;
   logic hw_halt;
   logic [15:0] reload_buf;
   logic [15:0] reload_act;
   logic [31:0] ctrl_next;
   logic ar_take;
   logic [31:0] read_word;
   logic [1:0] read_resp;

   // Write path: address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
      end else if (s_axi_awvalid && awready_q) begin
         aw_held_q <= 1'b1;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q <= 8'h00;
      end else if (s_axi_awvalid && awready_q) begin
         awaddr_q <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
      end else if (s_axi_wvalid && wready_q) begin
         w_held_q <= 1'b1;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && wready_q) begin
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
   end

   assign do_write = aw_held_q && w_held_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
      end else begin
         awready_q <= !aw_held_q && !(s_axi_awvalid && awready_q) && !bvalid_q;
      end
   end

   // Ready drops the cycle after a handshake so one beat is never taken twice
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_q <= 1'b0;
      end else begin
         wready_q <= !w_held_q && !(s_axi_wvalid && wready_q) && !bvalid_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp_q <= 2'b00;
      end else if (do_write) begin
         bresp_q <= (awaddr_q <= `EVENT_CTRL_OFFSET && awaddr_q[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end
   end

   always_comb begin
      wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   end

   assign ug_write = do_write && awaddr_q == `EVENT_CTRL_OFFSET && wstrb_q[0]
      && wdata_q[`UG_BIT];
   assign reload_write = do_write && awaddr_q == `RELOAD_BUFFER_OFFSET;

   // Update event sources, gated by the suppress bit
   assign any_update = (counter_wrap || ug_write || slave_update)
      && !ctrl_q[`SUPPRESS_BIT];
   assign hw_halt = any_update && ctrl_q[`SINGLE_SHOT_BIT];

   always_comb begin
      ctrl_next = ctrl_q;
      if (do_write && awaddr_q == `CTRL_ONE_OFFSET) begin
         ctrl_next = (ctrl_q & ~(wmask & `CTRL_ONE_WMASK))
            | (wdata_q & wmask & `CTRL_ONE_WMASK);
      end
      if (trigger_start) begin
         ctrl_next[`RUN_BIT] = 1'b1;
      end
      if (hw_halt) begin
         ctrl_next[`RUN_BIT] = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `CTRL_ONE_RESET;
      end else begin
         ctrl_q <= ctrl_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         update_event_q <= 1'b0;
      end else begin
         update_event_q <= any_update;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         update_request_q <= 1'b0;
      end else if (ctrl_q[`SOURCE_BIT]) begin
         update_request_q <= counter_wrap && !ctrl_q[`SUPPRESS_BIT];
      end else begin
         update_request_q <= any_update;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reinit_q <= 1'b0;
      end else begin
         reinit_q <= ug_write || slave_reset;
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~((do_write && awaddr_q == `IRQ_STATUS_OFFSET && wstrb_q[0])
            ? wdata_q[`IRQ_WIDTH-1:0] : '0))
            | {hw_halt, update_request_q};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= '0;
      end else if (do_write && awaddr_q == `IRQ_MASK_OFFSET && wstrb_q[0]) begin
         mask_q <= wdata_q[`IRQ_WIDTH-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= tick_raw;
      end
   end

   // Read path, one request at a time
   assign ar_take = s_axi_arvalid && arready_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
      end else if (ar_take) begin
         arready_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_comb begin
      read_word = 32'h0000_0000;
      read_resp = 2'b00;
      case (s_axi_araddr)
         `CTRL_ONE_OFFSET: read_word = ctrl_q;
         `RELOAD_ACTIVE_OFFSET: read_word = {16'h0000, reload_act};
         `RELOAD_BUFFER_OFFSET: read_word = {16'h0000, reload_buf};
         `IRQ_STATUS_OFFSET: read_word = {30'h0, status_q};
         `IRQ_MASK_OFFSET: read_word = {30'h0, mask_q};
         `EVENT_CTRL_OFFSET: read_word = 32'h0000_0000;
         default: read_resp = 2'b10;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'b00;
      end else if (ar_take) begin
         rdata_q <= read_word;
         rresp_q <= read_resp;
      end
   end

   sampling_divider u_divider (
      .aclk(aclk),
      .aresetn(aresetn),
      .div_code(ctrl_q[`DIV_MSB:`DIV_LSB]),
      .sample_tick(tick_raw)
   );

   // With buffering on, reload loads only on real update events, so suppression keeps the shadow
   reload_holder u_reload (
      .aclk(aclk),
      .aresetn(aresetn),
      .buffer_en(ctrl_q[`BUFFER_EN_BIT]),
      .write_en(reload_write),
      .write_value(wdata_q[15:0]),
      .update_event(any_update),
      .buffer_value(reload_buf),
      .active_value(reload_act)
   );

   logic [15:0] reload_out_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_out_q <= `RELOAD_RESET;
      end else begin
         reload_out_q <= reload_act;
      end
   end

   assign counter_run = ctrl_q[`RUN_BIT];
   assign update_event = update_event_q;
   assign update_request = update_request_q;
   assign counter_reinit = reinit_q;
   assign sample_tick = tick_q;
   assign reload_active = reload_out_q;
   assign irq = irq_q;
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule : timer_control_one

/* File: timer_control_one_chk.sv */
`timescale 1ns/1ps
module timer_control_one_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic counter_wrap,
   input wire logic slave_update,
   input wire logic slave_reset,
   input wire logic trigger_start,
   input wire logic counter_run,
   input wire logic update_event,
   input wire logic update_request,
   input wire logic counter_reinit,
   input wire logic sample_tick,
   input wire logic [15:0] reload_active,
   input wire logic irq
);
   logic [2:0] gap_q;
   logic [2:0] gap_d;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Slowest divider is four, so a gap of four cycles means a lost tick
   assign gap_d = sample_tick ? 3'h0 : gap_q + 3'h1;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_q <= 3'h0;
      end else begin
         gap_q <= gap_d;
      end
   end
   sequence s_b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence s_trig_alone;
      trigger_start && !counter_wrap && !slave_update && !update_event && s_axi_wready;
   endsequence
   AST_RESET_VALUES: assert property ($rose(aresetn) |->
      !counter_run && !irq && reload_active == 16'hFFFF) else $error("reset values wrong");
   AST_TICK_GAP: assert property (gap_q < 3'h4) else $error("sampling tick lost");
   AST_SLAVE_REINIT: assert property (slave_reset |=> counter_reinit)
      else $error("no reinit after slave reset");
   AST_REINIT_CAUSE: assert property (counter_reinit |-> $past(slave_reset)
      || !$past(s_axi_wready) || $past(s_axi_bvalid)) else $error("reinit without cause");
   AST_EVENT_CAUSE: assert property (update_event |-> $past(counter_wrap)
      || $past(slave_update) || !$past(s_axi_wready) || $past(s_axi_bvalid))
      else $error("update without cause");
   AST_REQ_NEEDS_EVENT: assert property (update_request |-> update_event)
      else $error("request without update");
   AST_TRIGGER_RUN: assert property (s_trig_alone |=> counter_run)
      else $error("trigger did not start");
   AST_RUN_RISE: assert property ($rose(counter_run) |-> $past(trigger_start)
      || !$past(s_axi_wready) || $past(s_axi_bvalid)) else $error("run rose alone");
   AST_BVALID_HOLD: assert property (s_b_wait |=> s_axi_bvalid)
      else $error("write response dropped");
endmodule : timer_control_one_chk

/* File: timer_control_one_tb_top.sv */
`timescale 1ns/1ps
module timer_control_one_tb_top;
   import timer_control_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, w;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic counter_wrap = 1'h0, slave_update = 1'h0, slave_reset = 1'h0, trigger_start = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic counter_run, update_event, update_request, counter_reinit, sample_tick, irq;
   logic [15:0] reload_active;
   int errors = 0, checked = 0, ev_n, rq_n, ri_n, tk_n;
   timer_control_one u_timer_control_one (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .counter_wrap(counter_wrap), .slave_update(slave_update),
      .slave_reset(slave_reset), .trigger_start(trigger_start), .counter_run(counter_run),
      .update_event(update_event), .update_request(update_request),
      .counter_reinit(counter_reinit), .sample_tick(sample_tick),
      .reload_active(reload_active), .irq(irq)
   );
   always #25 aclk = ~aclk;
   always @(posedge aclk) begin
      ev_n += update_event;
      rq_n += update_request;
      ri_n += counter_reinit;
      tk_n += sample_tick;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      check("bresp", s_axi_bresp, er);
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      check("rresp", s_axi_rresp, er);
      if (er == 2'h0) check("rdata", s_axi_rdata, e);
      @(posedge aclk);
   endtask : rd
   task automatic fire(input int k);
      @(posedge aclk);
      case (k)
         0: counter_wrap <= 1'h1;
         1: slave_update <= 1'h1;
         2: wr(8'h14, 32'h1, 2'h0);
         3: slave_reset <= 1'h1;
         default: trigger_start <= 1'h1;
      endcase
      @(posedge aclk);
      {counter_wrap, slave_update, slave_reset, trigger_start} <= 4'h0;
      repeat (2) @(posedge aclk);
   endtask : fire
   function automatic int exp_ev(int s, int k);
      return !s[0] && k < 3;
   endfunction : exp_ev
   function automatic int exp_rq(int s, int k);
      return !s[0] && (k == 0 || (!s[1] && k < 3));
   endfunction : exp_rq
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      print_verdict();
   end
   initial begin
      v = $urandom(32'h02FE0C9B);
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(8'h00, 32'h0, 2'h0);
      rd(8'h04, 32'hFFFF, 2'h0);
      $display("reset test done");
      repeat (4) begin
         v = $urandom() & 32'h38F;
         wr(8'h00, v, 2'h0);
         rd(8'h00, v, 2'h0);
      end
      wr(8'h20, 32'h1, 2'h2);
      rd(8'h22, 32'h0, 2'h2);
      $display("access test done");
      for (int c = 0; c < 4; c++) begin
         wr(8'h00, 32'(c) << 8, 2'h0);
         @(negedge aclk) tk_n = 0;
         repeat (16) @(negedge aclk);
         check("ticks", tk_n, c == 3 ? 16 : 16 >> c);
      end
      $display("divider test done");
      wr(8'h10, 32'h1, 2'h0);
      for (int s = 0; s < 4; s++) begin
         for (int k = 0; k < 4; k++) begin
            wr(8'h00, 32'(s) << 1, 2'h0);
            @(negedge aclk) ev_n = 0;
            rq_n = 0;
            ri_n = 0;
            fire(k);
            @(negedge aclk);
            check("update", ev_n, exp_ev(s, k));
            check("request", rq_n, exp_rq(s, k));
            check("reinit", ri_n, k >= 2);
         end
      end
      check("irq", irq, 1);
      wr(8'h10, 32'h0, 2'h0);
      check("irq", irq, 0);
      $display("update test done");
      v = {16'h0, 16'($urandom())};
      w = {16'h0, 16'($urandom())};
      if (w == v) begin
         w = v ^ 32'h0000_0001;
      end
      wr(8'h00, 32'h0, 2'h0);
      wr(8'h08, v, 2'h0);
      rd(8'h04, v, 2'h0);
      wr(8'h00, 32'h80, 2'h0);
      wr(8'h08, w, 2'h0);
      rd(8'h04, v, 2'h0);
      wr(8'h00, 32'h82, 2'h0);
      fire(0);
      fire(2);
      rd(8'h04, v, 2'h0);
      wr(8'h00, 32'h80, 2'h0);
      fire(0);
      check("reload", reload_active, w[15:0]);
      $display("reload test done");
      wr(8'h0C, 32'h3, 2'h0);
      wr(8'h10, 32'h2, 2'h0);
      wr(8'h00, 32'h9, 2'h0);
      check("run", counter_run, 1);
      fire(0);
      check("run", counter_run, 0);
      check("irq", irq, 1);
      rd(8'h0C, 32'h3, 2'h0);
      rd(8'h00, 32'h8, 2'h0);
      wr(8'h0C, 32'h3, 2'h0);
      check("irq", irq, 0);
      fire(4);
      check("run", counter_run, 1);
      wr(8'h00, 32'h1, 2'h0);
      fire(0);
      check("run", counter_run, 1);
      $display("run test done");
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(8'h00, 32'h0, 2'h0);
      rd(8'h04, 32'hFFFF, 2'h0);
      rd(8'h0C, 32'h0, 2'h0);
      $display("second reset test done");
      print_verdict();
   end
endmodule : timer_control_one_tb_top
bind timer_control_one timer_control_one_chk u_timer_control_one_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .counter_wrap(counter_wrap), .slave_update(slave_update),
   .slave_reset(slave_reset), .trigger_start(trigger_start), .counter_run(counter_run),
   .update_event(update_event), .update_request(update_request),
   .counter_reinit(counter_reinit), .sample_tick(sample_tick),
   .reload_active(reload_active), .irq(irq)
);

/* File: timer_control_pkg.sv */
package timer_control_pkg;
   typedef enum logic [1:0] {
      DIV_ONE = 2'b00,
      DIV_TWO = 2'b01,
      DIV_FOUR = 2'b10,
      DIV_RESERVED = 2'b11
   } sampling_div_t;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRESP = 2'b01,
      BUS_RRESP = 2'b10
   } bus_state_t;
endpackage : timer_control_pkg
